// [hw/eaiu_pkg.sv]
package eaiu_pkg;

   // Event numbering
   localparam int NUM_EVENTS = 34;
   localparam int EV_W = 6;
   localparam int RT_W = 7;
   localparam int NUM_PINS = 4;
   localparam int NUM_COUNTERS = 6;
   localparam logic [EV_W-1:0] EV_MAX = 6'h21;

   localparam int EV_PIN_BASE = 0;
   localparam int EV_PORT0_RX_CHAR = 8;
   localparam int EV_PORT0_TX_DONE = 9;
   localparam int EV_CYCLE_TIME_0 = 10;
   localparam int EV_CYCLE_TIME_1 = 11;
   localparam int EV_FC0_PRESET = 12;
   localparam int EV_FC1_PRESET = 13;
   localparam int EV_FC1_DIR = 14;
   localparam int EV_FC1_RESET = 15;
   localparam int EV_FC2_PRESET = 16;
   localparam int EV_FC2_DIR = 17;
   localparam int EV_FC2_RESET = 18;
   localparam int EV_PULSE_OUT_0 = 19;
   localparam int EV_PULSE_OUT_1 = 20;
   localparam int EV_MS_TIMER_A = 21;
   localparam int EV_MS_TIMER_B = 22;
   localparam int EV_PORT0_RX_MSG = 23;
   localparam int EV_PORT1_RX_MSG = 24;
   localparam int EV_PORT1_RX_CHAR = 25;
   localparam int EV_PORT1_TX_DONE = 26;
   localparam int EV_FC0_DIR = 27;
   localparam int EV_FC0_RESET = 28;
   localparam int EV_FC4_PRESET = 29;
   localparam int EV_FC4_DIR = 30;
   localparam int EV_FC4_RESET = 31;
   localparam int EV_FC3_PRESET = 32;
   localparam int EV_FC5_PRESET = 33;

   // Supported events per variant
   localparam logic [NUM_EVENTS-1:0] VARIANT_FULL = 34'h3_FFFF_FFFF;
   localparam logic [NUM_EVENTS-1:0] VARIANT_MID = 34'h3_F8FF_FFFF;
   localparam logic [NUM_EVENTS-1:0] VARIANT_SMALL = 34'h3_F8F8_1FFF;

   localparam int QUEUE_DEPTH = 16;

   // Error codes
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] ERR_IN_ROUTINE = 16'h0004;

   // Context widths
   localparam int STACK_W = 32;
   localparam int ACC_W = 32;
   localparam int NUM_ACC = 4;
   localparam int FLAG_W = 16;

   typedef enum logic [2:0] {
      CMD_BIND = 3'h0,
      CMD_UNBIND = 3'h1,
      CMD_GATE_OPEN = 3'h2,
      CMD_GATE_CLOSE = 3'h3,
      CMD_COUNTER_DEFINE = 3'h4,
      CMD_NOP = 3'h7
   } eaiu_cmd_t;

   typedef enum logic [1:0] {
      ST_MAIN = 2'b01,
      ST_ROUTINE = 2'b10
   } eaiu_state_t;

   typedef struct packed {
      logic port0_rx_char;
      logic port0_tx_done;
      logic port0_rx_msg;
      logic port1_rx_char;
      logic port1_tx_done;
      logic port1_rx_msg;
      logic cycle_time_0;
      logic cycle_time_1;
      logic ms_timer_a;
      logic ms_timer_b;
      logic [NUM_COUNTERS-1:0] count_equals_preset;
      logic [3:0] dir_changed;
      logic [3:0] ext_reset;
      logic [1:0] pulse_train_done;
   } eaiu_src_t;

   typedef struct packed {
      logic [STACK_W-1:0] logic_stack;
      logic [NUM_ACC-1:0][ACC_W-1:0] accum;
      logic [FLAG_W-1:0] status_flags;
   } eaiu_ctx_t;

   typedef struct packed {
      logic [EV_W-1:0] event_number;
      logic [RT_W-1:0] routine;
   } eaiu_entry_t;

endpackage

// [hw/eaiu_queue.sv]
`timescale 1ns/1ps
module eaiu_queue #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Fill side
   input wire logic push_valid,
   output logic push_ready,
   input wire logic [WIDTH-1:0] push_data,
   // Drain side
   output logic pop_valid,
   input wire logic pop_ready,
   output logic [WIDTH-1:0] pop_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic do_push, do_pop;

   assign push_ready = (cnt_q != FULL_COUNT);
   assign pop_valid = (cnt_q != '0);
   assign pop_data = mem_q[rd_q];
   assign do_push = push_valid && push_ready;
   assign do_pop = pop_valid && pop_ready;

   always_comb begin
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (do_push) begin
         mem_d[wr_q] = push_data;
         wr_d = (wr_q == LAST_SLOT) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
         rd_d = (rd_q == LAST_SLOT) ? '0 : rd_q + 1'b1;
      end
      if (do_push && !do_pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (do_pop && !do_push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

// [hw/eaiu_top.sv]
`timescale 1ns/1ps
// How it works
// [R1] Bind records routine and enables event
// [R2] Many events may share one routine
// [R3] Closed gate still queues enabled events
// [R4] Unbind clears binding, later occurrences ignored
// [R5] Edge, port 0 and port 1 events
// [R6] Cyclic timers 10,11; ms timers 21,22
// [R7] Counter preset events 12,13,16,32,29,33
// [R8] Direction and reset counter events mapped
// [R9] Pulse train done raises 19 and 20
// [R10] Last instruction or true return resumes main
// [R11] Routines avoid gate, define, end instructions
// [R12] Context saved on entry, restored on return
// [R13] Dispatch only at instruction boundaries
// [R14] No dispatch while gate is closed
// [R15] One subroutine level, shared context
// [R16] Gate closes on every run entry
// [R17] Gate or define inside routine: error 0004
// [R18] Running routine never pre-empted
// [R19] Full queue drops event, sets overflow; code holds one per event in staging, drops only a repeat still staged
// [R20] Unsupported or disabled events ignored
module eaiu_top #(
   parameter logic [eaiu_pkg::NUM_EVENTS-1:0] SUPPORTED = eaiu_pkg::VARIANT_FULL,
   parameter int QDEPTH = eaiu_pkg::QUEUE_DEPTH
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // Instruction command port
   input wire logic CMD_VALID,
   input wire eaiu_pkg::eaiu_cmd_t CMD_OP,
   input wire logic [eaiu_pkg::EV_W-1:0] CMD_EVENT,
   input wire logic [eaiu_pkg::RT_W-1:0] CMD_ROUTINE,
   output logic CMD_DONE,
   output logic CMD_ENO,
   output logic [15:0] CMD_ERROR,
   output logic COUNTER_DEFINE,
   // Sequencer control
   input wire logic RUN_ENTRY,
   input wire logic INSN_BOUNDARY,
   input wire logic ROUTINE_LAST_DONE,
   input wire logic COND_RETURN,
   input wire logic COND_TRUE,
   input wire logic SUB_CALL,
   input wire logic SUB_RETURN,
   input wire eaiu_pkg::eaiu_ctx_t CTX_LIVE,
   // Dispatch and return
   output logic DISPATCH,
   output logic [eaiu_pkg::RT_W-1:0] DISPATCH_ROUTINE,
   output logic [eaiu_pkg::EV_W-1:0] DISPATCH_EVENT,
   output logic IN_ROUTINE,
   output logic RETURN_STB,
   output eaiu_pkg::eaiu_ctx_t CTX_RESTORE,
   output logic NEST_ERR,
   // Status
   output logic GATE_OPEN,
   output logic QUEUE_OVERFLOW,
   // Event sources
   input wire logic [eaiu_pkg::NUM_PINS-1:0] EDGE_PINS,
   input wire eaiu_pkg::eaiu_src_t EVENT_SRC
);
   localparam int NE = eaiu_pkg::NUM_EVENTS;
   localparam int NP = eaiu_pkg::NUM_PINS;

   // Pin synchronisers
   logic [NP-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
   logic [NP-1:0] pin_s1_d, pin_s2_d, pin_s3_d;

   always_comb begin
      pin_s1_d = EDGE_PINS;
      pin_s2_d = pin_s1_q;
      pin_s3_d = pin_s2_q;
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
      end else begin
         pin_s1_q <= pin_s1_d;
         pin_s2_q <= pin_s2_d;
         pin_s3_q <= pin_s3_d;
      end
   end

   // Raw event vector
   logic [NE-1:0] raw_ev;
   always_comb begin
      raw_ev = '0;
      for (int p = 0; p < NP; p++) begin
         raw_ev[eaiu_pkg::EV_PIN_BASE + 2*p] = pin_s2_q[p] && !pin_s3_q[p]; // [R5]
         raw_ev[eaiu_pkg::EV_PIN_BASE + 2*p + 1] = !pin_s2_q[p] && pin_s3_q[p]; // [R5]
      end
      raw_ev[eaiu_pkg::EV_PORT0_RX_CHAR] = EVENT_SRC.port0_rx_char; // [R5]
      raw_ev[eaiu_pkg::EV_PORT0_TX_DONE] = EVENT_SRC.port0_tx_done; // [R5]
      raw_ev[eaiu_pkg::EV_PORT0_RX_MSG] = EVENT_SRC.port0_rx_msg; // [R5]
      raw_ev[eaiu_pkg::EV_PORT1_RX_MSG] = EVENT_SRC.port1_rx_msg; // [R5]
      raw_ev[eaiu_pkg::EV_PORT1_RX_CHAR] = EVENT_SRC.port1_rx_char; // [R5]
      raw_ev[eaiu_pkg::EV_PORT1_TX_DONE] = EVENT_SRC.port1_tx_done; // [R5]
      raw_ev[eaiu_pkg::EV_CYCLE_TIME_0] = EVENT_SRC.cycle_time_0; // [R6]
      raw_ev[eaiu_pkg::EV_CYCLE_TIME_1] = EVENT_SRC.cycle_time_1; // [R6]
      raw_ev[eaiu_pkg::EV_MS_TIMER_A] = EVENT_SRC.ms_timer_a; // [R6]
      raw_ev[eaiu_pkg::EV_MS_TIMER_B] = EVENT_SRC.ms_timer_b; // [R6]
      raw_ev[eaiu_pkg::EV_FC0_PRESET] = EVENT_SRC.count_equals_preset[0]; // [R7]
      raw_ev[eaiu_pkg::EV_FC1_PRESET] = EVENT_SRC.count_equals_preset[1]; // [R7]
      raw_ev[eaiu_pkg::EV_FC2_PRESET] = EVENT_SRC.count_equals_preset[2]; // [R7]
      raw_ev[eaiu_pkg::EV_FC3_PRESET] = EVENT_SRC.count_equals_preset[3]; // [R7]
      raw_ev[eaiu_pkg::EV_FC4_PRESET] = EVENT_SRC.count_equals_preset[4]; // [R7]
      raw_ev[eaiu_pkg::EV_FC5_PRESET] = EVENT_SRC.count_equals_preset[5]; // [R7]
      raw_ev[eaiu_pkg::EV_FC0_DIR] = EVENT_SRC.dir_changed[0]; // [R8]
      raw_ev[eaiu_pkg::EV_FC1_DIR] = EVENT_SRC.dir_changed[1]; // [R8]
      raw_ev[eaiu_pkg::EV_FC2_DIR] = EVENT_SRC.dir_changed[2]; // [R8]
      raw_ev[eaiu_pkg::EV_FC4_DIR] = EVENT_SRC.dir_changed[3]; // [R8]
      raw_ev[eaiu_pkg::EV_FC0_RESET] = EVENT_SRC.ext_reset[0]; // [R8]
      raw_ev[eaiu_pkg::EV_FC1_RESET] = EVENT_SRC.ext_reset[1]; // [R8]
      raw_ev[eaiu_pkg::EV_FC2_RESET] = EVENT_SRC.ext_reset[2]; // [R8]
      raw_ev[eaiu_pkg::EV_FC4_RESET] = EVENT_SRC.ext_reset[3]; // [R8]
      raw_ev[eaiu_pkg::EV_PULSE_OUT_0] = EVENT_SRC.pulse_train_done[0]; // [R9]
      raw_ev[eaiu_pkg::EV_PULSE_OUT_1] = EVENT_SRC.pulse_train_done[1]; // [R9]
   end

   // Binding table and gate
   logic [eaiu_pkg::RT_W-1:0] bind_q [NE];
   logic [eaiu_pkg::RT_W-1:0] bind_d [NE];
   logic [NE-1:0] enable_q, enable_d;
   logic gate_q, gate_d;
   logic done_q, done_d, eno_q, eno_d, def_q, def_d;
   logic [15:0] err_q, err_d;
   logic ev_ok;
   logic in_routine;

   assign ev_ok = (CMD_EVENT <= eaiu_pkg::EV_MAX) && SUPPORTED[CMD_EVENT];

   always_comb begin
      bind_d = bind_q;
      enable_d = enable_q;
      gate_d = gate_q;
      done_d = CMD_VALID;
      eno_d = 1'b1;
      err_d = eaiu_pkg::ERR_NONE;
      def_d = 1'b0;
      if (CMD_VALID) begin
         case (CMD_OP)
            eaiu_pkg::CMD_BIND: begin
               if (ev_ok) begin
                  bind_d[CMD_EVENT] = CMD_ROUTINE; // [R1] [R2]
                  enable_d[CMD_EVENT] = 1'b1; // [R1]
               end else begin
                  eno_d = 1'b0;
               end
            end
            eaiu_pkg::CMD_UNBIND: begin
               if (ev_ok) begin
                  bind_d[CMD_EVENT] = '0; // [R4]
                  enable_d[CMD_EVENT] = 1'b0; // [R4]
               end else begin
                  eno_d = 1'b0;
               end
            end
            eaiu_pkg::CMD_GATE_OPEN, eaiu_pkg::CMD_GATE_CLOSE,
            eaiu_pkg::CMD_COUNTER_DEFINE: begin
               if (in_routine) begin
                  eno_d = 1'b0; // [R17]
                  err_d = eaiu_pkg::ERR_IN_ROUTINE; // [R17]
               end else if (CMD_OP == eaiu_pkg::CMD_GATE_OPEN) begin
                  gate_d = 1'b1;
               end else if (CMD_OP == eaiu_pkg::CMD_GATE_CLOSE) begin
                  gate_d = 1'b0;
               end else begin
                  def_d = 1'b1;
               end
            end
            default: ;
         endcase
      end
      if (RUN_ENTRY) begin
         gate_d = 1'b0; // [R16]
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         for (int e = 0; e < NE; e++) begin
            bind_q[e] <= '0;
         end
         enable_q <= '0;
         gate_q <= 1'b0;
         done_q <= 1'b0;
         eno_q <= 1'b0;
         err_q <= eaiu_pkg::ERR_NONE;
         def_q <= 1'b0;
      end else begin
         bind_q <= bind_d;
         enable_q <= enable_d;
         gate_q <= gate_d;
         done_q <= done_d;
         eno_q <= eno_d;
         err_q <= err_d;
         def_q <= def_d;
      end
   end

   // Staging into the queue
   logic [NE-1:0] occ, stage_q, stage_d;
   logic ovf_q, ovf_d;
   logic push_valid, push_ready, pop_valid, pop_ready;
   eaiu_pkg::eaiu_entry_t push_entry, pop_entry;
   logic [eaiu_pkg::EV_W-1:0] pick;
   logic ret;

   // Gate not consulted: closed gate queues
   assign occ = raw_ev & enable_q & SUPPORTED; // [R3] [R4] [R20]

   always_comb begin
      pick = '0;
      push_valid = 1'b0;
      for (int e = NE - 1; e >= 0; e--) begin
         if (stage_q[e]) begin
            pick = eaiu_pkg::EV_W'(e);
            push_valid = 1'b1;
         end
      end
      push_entry.event_number = pick;
      push_entry.routine = bind_q[pick];
      stage_d = stage_q;
      if (push_valid && push_ready) begin
         stage_d[pick] = 1'b0;
      end
      ovf_d = ovf_q;
      if (ret && !pop_valid) begin
         ovf_d = 1'b0;
      end
      for (int e = 0; e < NE; e++) begin
         if (occ[e]) begin
            if (stage_d[e]) begin
               ovf_d = 1'b1; // [R19]
            end
            stage_d[e] = 1'b1; // [R3]
         end
         if (!enable_d[e]) begin
            stage_d[e] = 1'b0; // [R4]
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         stage_q <= '0;
         ovf_q <= 1'b0;
      end else begin
         stage_q <= stage_d;
         ovf_q <= ovf_d;
      end
   end

   eaiu_queue #(
      .WIDTH($bits(eaiu_pkg::eaiu_entry_t)),
      .DEPTH(QDEPTH)
   ) u_queue (
      .clk(SYS_CLK),
      .reset_n(RESET_N),
      .push_valid(push_valid),
      .push_ready(push_ready),
      .push_data(push_entry),
      .pop_valid(pop_valid),
      .pop_ready(pop_ready),
      .pop_data(pop_entry)
   );

   // Dispatch sequencer
   eaiu_pkg::eaiu_state_t st_q, st_d;
   eaiu_pkg::eaiu_ctx_t ctx_q, ctx_d;
   logic disp_q, disp_d, ret_q, ret_d, nest_q, nest_d, sub_q, sub_d;
   logic [eaiu_pkg::RT_W-1:0] rt_q, rt_d;
   logic [eaiu_pkg::EV_W-1:0] dev_q, dev_d;

   assign in_routine = (st_q == eaiu_pkg::ST_ROUTINE);
   assign ret = in_routine && (ROUTINE_LAST_DONE || (COND_RETURN && COND_TRUE)); // [R10]
   assign pop_ready = (st_q == eaiu_pkg::ST_MAIN) && gate_q && INSN_BOUNDARY; // [R13] [R14]

   always_comb begin
      st_d = st_q;
      ctx_d = ctx_q;
      rt_d = rt_q;
      dev_d = dev_q;
      sub_d = sub_q;
      disp_d = 1'b0;
      ret_d = 1'b0;
      nest_d = 1'b0;
      case (st_q)
         eaiu_pkg::ST_MAIN: begin
            if (pop_ready && pop_valid) begin
               ctx_d = CTX_LIVE; // [R12]
               rt_d = pop_entry.routine;
               dev_d = pop_entry.event_number;
               disp_d = 1'b1;
               sub_d = 1'b0;
               st_d = eaiu_pkg::ST_ROUTINE;
            end
         end
         eaiu_pkg::ST_ROUTINE: begin
            // No pop here: no pre-emption
            if (ret) begin
               ret_d = 1'b1; // [R10] [R12] [R18]
               sub_d = 1'b0;
               st_d = eaiu_pkg::ST_MAIN;
            end else if (SUB_CALL) begin
               nest_d = sub_q; // [R15]
               sub_d = 1'b1; // [R15]
            end else if (SUB_RETURN) begin
               sub_d = 1'b0;
            end
         end
         default: begin
            st_d = eaiu_pkg::ST_MAIN;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_q <= eaiu_pkg::ST_MAIN;
         ctx_q <= '0;
         rt_q <= '0;
         dev_q <= '0;
         sub_q <= 1'b0;
         disp_q <= 1'b0;
         ret_q <= 1'b0;
         nest_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ctx_q <= ctx_d;
         rt_q <= rt_d;
         dev_q <= dev_d;
         sub_q <= sub_d;
         disp_q <= disp_d;
         ret_q <= ret_d;
         nest_q <= nest_d;
      end
   end

   assign CMD_DONE = done_q;
   assign CMD_ENO = eno_q;
   assign CMD_ERROR = err_q;
   assign COUNTER_DEFINE = def_q;
   assign DISPATCH = disp_q;
   assign DISPATCH_ROUTINE = rt_q;
   assign DISPATCH_EVENT = dev_q;
   assign IN_ROUTINE = in_routine;
   assign RETURN_STB = ret_q;
   assign CTX_RESTORE = ctx_q;
   assign NEST_ERR = nest_q;
   assign GATE_OPEN = gate_q;
   assign QUEUE_OVERFLOW = ovf_q;
endmodule

// [sim/eaiu_properties.sv]
`timescale 1ns/1ps
module eaiu_properties (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // Commands
   input wire logic CMD_VALID,
   input wire eaiu_pkg::eaiu_cmd_t CMD_OP,
   input wire logic CMD_DONE,
   input wire logic CMD_ENO,
   input wire logic [15:0] CMD_ERROR,
   input wire logic COUNTER_DEFINE,
   // Sequencer
   input wire logic RUN_ENTRY,
   input wire logic INSN_BOUNDARY,
   input wire logic ROUTINE_LAST_DONE,
   input wire logic COND_RETURN,
   input wire logic COND_TRUE,
   input wire eaiu_pkg::eaiu_ctx_t CTX_LIVE,
   // Dispatch and status
   input wire logic DISPATCH,
   input wire logic [eaiu_pkg::EV_W-1:0] DISPATCH_EVENT,
   input wire logic IN_ROUTINE,
   input wire logic RETURN_STB,
   input wire eaiu_pkg::eaiu_ctx_t CTX_RESTORE,
   input wire logic GATE_OPEN,
   input wire logic QUEUE_OVERFLOW
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RESET_N);
   sequence ret_req;
      IN_ROUTINE && (ROUTINE_LAST_DONE || (COND_RETURN && COND_TRUE));
   endsequence
   sequence ret_ack;
      RETURN_STB && !IN_ROUTINE;
   endsequence
   sequence ctl_in_rt;
      CMD_VALID && IN_ROUTINE && (CMD_OP inside {eaiu_pkg::CMD_GATE_OPEN,
         eaiu_pkg::CMD_GATE_CLOSE, eaiu_pkg::CMD_COUNTER_DEFINE});
   endsequence
   cmd_answer_a:
   assert property (CMD_VALID |=> CMD_DONE) else $error("no answer");
   routine_err_a:
   assert property (ctl_in_rt |=> CMD_DONE && !CMD_ENO && !COUNTER_DEFINE
      && CMD_ERROR == eaiu_pkg::ERR_IN_ROUTINE) else $error("bad error");
   define_ok_a:
   assert property (CMD_VALID && !IN_ROUTINE && CMD_OP == eaiu_pkg::CMD_COUNTER_DEFINE
      |=> CMD_ENO && COUNTER_DEFINE && CMD_ERROR == eaiu_pkg::ERR_NONE)
      else $error("define refused");
   run_close_a:
   assert property (RUN_ENTRY |=> !GATE_OPEN) else $error("gate open");
   closed_gate_a:
   assert property (DISPATCH |-> $past(GATE_OPEN)) else $error("gate closed");
   boundary_a:
   assert property (DISPATCH |-> $past(INSN_BOUNDARY)) else $error("mid insn");
   no_preempt_a:
   assert property (IN_ROUTINE |=> !DISPATCH) else $error("pre-empted");
   return_a:
   assert property (ret_req |=> ret_ack) else $error("no return");
   false_cond_a:
   assert property (IN_ROUTINE && COND_RETURN && !COND_TRUE && !ROUTINE_LAST_DONE
      |=> !RETURN_STB) else $error("false return");
   ctx_save_a:
   assert property (DISPATCH |-> CTX_RESTORE == $past(CTX_LIVE)) else $error("context lost");
   ctx_hold_a:
   assert property (IN_ROUTINE && !DISPATCH |-> $stable(CTX_RESTORE))
      else $error("context moved");
   ovf_sticky_a:
   assert property ($fell(QUEUE_OVERFLOW) |-> RETURN_STB) else $error("not sticky");
   event_range_a:
   assert property (DISPATCH |-> DISPATCH_EVENT <= eaiu_pkg::EV_MAX)
      else $error("bad event");
endmodule

bind eaiu_top eaiu_properties i_props (
   .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
   .CMD_DONE(CMD_DONE), .CMD_ENO(CMD_ENO), .CMD_ERROR(CMD_ERROR),
   .COUNTER_DEFINE(COUNTER_DEFINE), .RUN_ENTRY(RUN_ENTRY), .INSN_BOUNDARY(INSN_BOUNDARY),
   .ROUTINE_LAST_DONE(ROUTINE_LAST_DONE), .COND_RETURN(COND_RETURN),
   .COND_TRUE(COND_TRUE), .CTX_LIVE(CTX_LIVE), .DISPATCH(DISPATCH),
   .DISPATCH_EVENT(DISPATCH_EVENT), .IN_ROUTINE(IN_ROUTINE), .RETURN_STB(RETURN_STB),
   .CTX_RESTORE(CTX_RESTORE), .GATE_OPEN(GATE_OPEN), .QUEUE_OVERFLOW(QUEUE_OVERFLOW)
);

// [sim/eaiu_seq_model.sv]
`timescale 1ns/1ps
module eaiu_seq_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // From the unit, and run length from the bench
   input wire logic dispatch,
   input wire logic return_stb,
   input wire logic [5:0] run_len,
   // To the unit
   output logic insn_boundary,
   output logic last_done,
   output logic cond_return,
   output logic cond_true,
   output logic sub_call,
   output logic sub_return,
   output eaiu_pkg::eaiu_ctx_t ctx_live
);
   logic [15:0] tick = '0;
   logic busy = 1'b0;
   logic alt = 1'b0;
   int cnt = 0;
   initial begin
      {insn_boundary, last_done, cond_return, cond_true, sub_call, sub_return} = '0;
      ctx_live = '0;
   end
   always @(negedge clk) begin
      tick <= tick + 16'h0001;
      ctx_live <= {11{tick}};
      last_done <= 1'b0;
      cond_return <= 1'b0;
      sub_call <= 1'b0;
      sub_return <= 1'b0;
      // Long instruction every fourth cycle while no routine runs
      insn_boundary <= busy | (tick[1:0] != 2'h3);
      if (!reset_n) begin
         busy <= 1'b0;
      end else if (dispatch) begin
         busy <= 1'b1;
         cnt <= run_len;
      end else if (return_stb) begin
         busy <= 1'b0;
      end else if (busy) begin
         // Body issues no gate, define or end command
         cnt <= cnt - 1;
         sub_call <= (cnt == run_len - 1);
         sub_return <= (cnt == run_len - 2);
         if (cnt == 2) begin
            cond_return <= 1'b1;
         end
         // Alternate both return kinds
         if (cnt == 1) begin
            alt <= ~alt;
            cond_return <= alt;
            last_done <= ~alt;
         end
         cond_true <= (cnt == 1) & alt;
      end
   end
endmodule

// [sim/event_attach_interrupt_unit_bench.sv]
`timescale 1ns/1ps
module event_attach_interrupt_unit_bench;
   localparam logic [33:0] SUP = eaiu_pkg::VARIANT_MID;
   // Event of each source bit, top bit of the struct first
   localparam int MAP[26] = '{8, 9, 23, 25, 26, 24, 10, 11, 21, 22, 33, 29, 32, 16, 13, 12,
      30, 17, 14, 27, 31, 18, 15, 28, 20, 19};
   logic clk = 0;
   logic rst_n = 0;
   logic cmd_valid = 0;
   logic run_entry = 0;
   eaiu_pkg::eaiu_cmd_t cmd_op = eaiu_pkg::CMD_NOP;
   logic [5:0] cmd_event = '0;
   logic [6:0] cmd_rt = '0;
   logic [3:0] pins = '0;
   eaiu_pkg::eaiu_src_t src = '0;
   logic [5:0] run_len = 6'h04;
   logic cmd_done, cmd_eno, cnt_def, dispatch, in_rt, ret_stb, gate_open, q_ovf;
   logic insn_b, last_done, cond_ret, cond_true, sub_call, sub_ret;
   logic [15:0] cmd_error;
   logic [6:0] d_rt;
   logic [5:0] d_ev;
   eaiu_pkg::eaiu_ctx_t ctx_live;
   int seed = 6256;
   int bad_count = 0;
   int comparisons = 0;
   int n = 0;
   logic [6:0] rt_of[34];
   logic [5:0] ev_q[$];
   logic [6:0] rt_q[$];

   always #2 clk = ~clk;

   eaiu_top #(.SUPPORTED(SUP), .QDEPTH(4)) i_dut (
      .SYS_CLK(clk), .RESET_N(rst_n), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
      .CMD_EVENT(cmd_event), .CMD_ROUTINE(cmd_rt), .CMD_DONE(cmd_done), .CMD_ENO(cmd_eno),
      .CMD_ERROR(cmd_error), .COUNTER_DEFINE(cnt_def), .RUN_ENTRY(run_entry),
      .INSN_BOUNDARY(insn_b), .ROUTINE_LAST_DONE(last_done), .COND_RETURN(cond_ret),
      .COND_TRUE(cond_true), .SUB_CALL(sub_call), .SUB_RETURN(sub_ret),
      .CTX_LIVE(ctx_live), .DISPATCH(dispatch), .DISPATCH_ROUTINE(d_rt),
      .DISPATCH_EVENT(d_ev), .IN_ROUTINE(in_rt), .RETURN_STB(ret_stb), .CTX_RESTORE(),
      .NEST_ERR(), .GATE_OPEN(gate_open), .QUEUE_OVERFLOW(q_ovf), .EDGE_PINS(pins),
      .EVENT_SRC(src)
   );
   eaiu_seq_model i_seq (
      .clk(clk), .reset_n(rst_n), .dispatch(dispatch), .return_stb(ret_stb),
      .run_len(run_len), .insn_boundary(insn_b), .last_done(last_done),
      .cond_return(cond_ret), .cond_true(cond_true), .sub_call(sub_call),
      .sub_return(sub_ret), .ctx_live(ctx_live)
   );

   always @(posedge clk) begin
      if (dispatch === 1'b1) begin
         ev_q.push_back(d_ev);
         rt_q.push_back(d_rt);
      end
   end

   function automatic eaiu_pkg::eaiu_src_t ev_src(input int k);
      eaiu_pkg::eaiu_src_t s;
      for (int i = 0; i < 26; i++) s[25-i] = (MAP[i] == k);
      return s;
   endfunction

   task fail(input string m);
      bad_count++;
      $display("ERROR %0t %s", $time, m);
   endtask
   task chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) fail("flag mismatch");
   endtask
   task chk_num(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) fail("value mismatch");
   endtask
   task chk_disp(input int k, input logic [6:0] rt);
      chk_num(16'(ev_q[n-1]), 16'(k));
      chk_num(16'(rt_q[n-1]), 16'(rt));
   endtask
   task cmd(input eaiu_pkg::eaiu_cmd_t op, input int ev, input int rt, input logic enable_out_flag,
            input logic [15:0] err);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_event = 6'(ev);
      cmd_rt = 7'(rt);
      @(negedge clk);
      cmd_valid = 1'b0;
      chk_bit(cmd_done, 1'b1);
      chk_bit(cmd_eno, enable_out_flag);
      chk_num(cmd_error, err);
   endtask
   // Pins toggle: even rises, odd falls
   task pulse(input int k);
      @(negedge clk);
      if (k < 8) pins[k/2] = ~pins[k/2];
      else src = ev_src(k);
      @(negedge clk);
      src = '0;
   endtask
   task settle(input int cnt, input logic idle);
      int i;
      for (i = 0; i < 500 && (ev_q.size() < cnt || (idle && in_rt !== 1'b0)); i++) begin
         @(negedge clk);
      end
      if (i == 500) begin
         fail("wait timed out");
         test_done();
      end
   endtask
   task test_done();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      chk_bit(gate_open, 1'b0);
      chk_bit(q_ovf, 1'b0);
      for (int k = 0; k < 34; k++) rt_of[k] = 7'($random(seed)) & 7'h0F;
      rt_of[5] = rt_of[4];
      rt_of[33] = 7'h7F;
      for (int k = 0; k < 34; k++) cmd(eaiu_pkg::CMD_BIND, k, rt_of[k], SUP[k], 16'h0000);
      cmd(eaiu_pkg::CMD_BIND, 34, 1, 1'b0, 16'h0000);
      cmd(eaiu_pkg::CMD_GATE_OPEN, 0, 0, 1'b1, 16'h0000);
      for (int k = 0; k < 34; k++) begin
         run_len = 6'(4 + ($random(seed) & 7));
         pulse(k);
         if (SUP[k]) n++;
         repeat (6) @(negedge clk);
         settle(n, 1'b1);
         chk_num(16'(ev_q.size()), 16'(n));
         if (SUP[k]) chk_disp(k, rt_of[k]);
      end
      $display("event map test done");
      cmd(eaiu_pkg::CMD_GATE_CLOSE, 0, 0, 1'b1, 16'h0000);
      pulse(8);
      pulse(10);
      pulse(12);
      repeat (10) @(negedge clk);
      chk_num(16'(ev_q.size()), 16'(n));
      cmd(eaiu_pkg::CMD_GATE_OPEN, 0, 0, 1'b1, 16'h0000);
      n += 3;
      settle(n, 1'b1);
      for (int i = 0; i < 3; i++) chk_num(16'(ev_q[n-3+i]), 16'(8 + 2 * i));
      $display("closed gate test done");
      cmd(eaiu_pkg::CMD_BIND, 8, 7'h55, 1'b1, 16'h0000);
      cmd(eaiu_pkg::CMD_UNBIND, 12, 0, 1'b1, 16'h0000);
      pulse(12);
      pulse(8);
      n++;
      settle(n, 1'b1);
      repeat (10) @(negedge clk);
      chk_disp(8, 7'h55);
      chk_num(16'(ev_q.size()), 16'(n));
      $display("rebind test done");
      run_len = 6'h28;
      pulse(10);
      n++;
      settle(n, 1'b0);
      cmd(eaiu_pkg::CMD_GATE_CLOSE, 0, 0, 1'b0, eaiu_pkg::ERR_IN_ROUTINE);
      cmd(eaiu_pkg::CMD_COUNTER_DEFINE, 0, 0, 1'b0, eaiu_pkg::ERR_IN_ROUTINE);
      cmd(eaiu_pkg::CMD_GATE_OPEN, 0, 0, 1'b0, eaiu_pkg::ERR_IN_ROUTINE);
      pulse(11);
      chk_bit(gate_open, 1'b1);
      n++;
      settle(n, 1'b1);
      chk_disp(11, rt_of[11]);
      cmd(eaiu_pkg::CMD_COUNTER_DEFINE, 0, 0, 1'b1, 16'h0000);
      $display("in routine test done");
      run_len = 6'h04;
      cmd(eaiu_pkg::CMD_GATE_CLOSE, 0, 0, 1'b1, 16'h0000);
      repeat (8) pulse(10);
      chk_bit(q_ovf, 1'b1);
      cmd(eaiu_pkg::CMD_GATE_OPEN, 0, 0, 1'b1, 16'h0000);
      n += 5;
      settle(n, 1'b1);
      repeat (10) @(negedge clk);
      chk_num(16'(ev_q.size()), 16'(n));
      chk_bit(q_ovf, 1'b0);
      $display("overflow test done");
      @(negedge clk);
      run_entry = 1'b1;
      @(negedge clk);
      run_entry = 1'b0;
      chk_bit(gate_open, 1'b0);
      pulse(9);
      repeat (10) @(negedge clk);
      chk_num(16'(ev_q.size()), 16'(n));
      $display("run entry test done");
      test_done();
   end
endmodule
